// ==== src/adcc_converter_control.sv ====
// converter control: sar sequencing, oversampling, dac path, command receiver
`timescale 1ns/10ps
module adcc_converter_control import adcc_pkg::*; #(
	parameter int UART_BIT_CYCLES = UART_BIT_CYC
) (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// configuration from the command interpreter
	input wire adcc_adc_cfg_t adcCfg,
	input wire adcc_dac_cfg_t dacCfg,
	input wire logic pinAltFunc,
	input wire logic [11:0] dacCode,
	input wire logic dacCodeValid,
	// sar analog macro
	input wire logic sarDone,
	input wire logic [11:0] sarData,
	output logic sarStart,
	output adcc_chan_t sarChan,
	output adcc_filt_t sarFilt,
	output adcc_aref_t sarRef,
	output logic sarLowRes,
	// conversion results
	output logic [15:0] result,
	output logic resultValid,
	// dac macro and pin functions
	output logic [11:0] dacOut,
	output logic dacStrobe,
	output adcc_dref_t dacRef,
	output logic inputPinAnalog,
	output logic outputPinAnalog,
	// serial command link
	input wire logic uartRx,
	output logic [7:0] rxByte,
	output logic rxValid,
	output logic rxFrameErr
);
	// ************************************************************
	// configuration capture
	// ************************************************************
	adcc_adc_cfg_t adcCfg_reg;
	adcc_dac_cfg_t dacCfg_reg;
	// reset defaults leave both converters idle until configured
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			adcCfg_reg <= ADC_CFG_RST;
			dacCfg_reg <= DAC_CFG_RST;
		end else begin
			adcCfg_reg <= adcCfg;
			dacCfg_reg <= dacCfg;
		end
	end
	// ************************************************************
	// adc sample rate divider
	// ************************************************************
	logic [RATE_CW-1:0] adcCnt_reg;
	wire [RATE_CW-1:0] adcPer = adcCfg_reg.lowRes ? RATE_CW'(ADC6_PER - 1) :
		RATE_CW'(ADC12_PER - 1);
	wire adcTick = adcCfg_reg.enable && (adcCnt_reg == '0);
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) adcCnt_reg <= '0;
		else if (!adcCfg_reg.enable || adcCnt_reg == '0) adcCnt_reg <= adcPer;
		else adcCnt_reg <= adcCnt_reg - 1'b1;
	end
	// ************************************************************
	// conversion sequencing and accumulate-and-dump
	// ************************************************************
	typedef enum logic [1:0] {A_IDLE = 2'b00, A_WAIT = 2'b01} adcc_astate_t;
	adcc_astate_t aState_reg;
	logic [ACC_W-1:0] acc_reg;
	logic [8:0] accCnt_reg;
	// oversampling ratio clamped to the range the accumulator holds
	wire [3:0] osLog2 = (adcCfg_reg.osLog2 < OS_LOG2_MIN) ? OS_LOG2_MIN :
		(adcCfg_reg.osLog2 > OS_LOG2_MAX) ? OS_LOG2_MAX : adcCfg_reg.osLog2;
	wire [11:0] sample = adcCfg_reg.lowRes ? {6'h00, sarData[11:6]} : sarData;
	wire take = (aState_reg == A_WAIT) && sarDone;
	wire [ACC_W-1:0] accSum = acc_reg + {8'h00, sample};
	wire [8:0] accCntNext = accCnt_reg + 1'b1;
	wire [8:0] osTarget = 9'h001 << osLog2;
	wire accDump = accCntNext >= osTarget; // a ratio lowered mid-run dumps at once, no overrun
	// scale the sum to sixteen bits; below 16x the low bits are only padding
	wire [ACC_W-1:0] accDown = accSum >> (osLog2 - OS_RES_LOG2);
	wire [ACC_W-1:0] accUp = accSum << (OS_RES_LOG2 - osLog2);
	wire [15:0] osResult = (osLog2 >= OS_RES_LOG2) ? accDown[15:0] : accUp[15:0];
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			aState_reg <= A_IDLE;
			acc_reg <= '0;
			accCnt_reg <= '0;
			result <= '0;
			resultValid <= 1'b0;
		end else begin
			resultValid <= 1'b0;
			case (aState_reg)
				A_IDLE: begin
					if (adcTick) aState_reg <= A_WAIT;
					if (!adcCfg_reg.osEnable) begin
						acc_reg <= '0;
						accCnt_reg <= '0;
					end
				end
				A_WAIT: begin
					if (take) begin
						aState_reg <= A_IDLE;
						if (!adcCfg_reg.osEnable) begin
							result <= {4'h0, sample};
							resultValid <= 1'b1;
						end else if (accDump) begin
							result <= osResult;
							resultValid <= 1'b1;
							acc_reg <= '0;
							accCnt_reg <= '0;
						end else begin
							acc_reg <= accSum;
							accCnt_reg <= accCntNext;
						end
					end
				end
				default: aState_reg <= A_IDLE;
			endcase
		end
	end
	// ************************************************************
	// sar macro controls and pin ownership
	// ************************************************************
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			sarStart <= 1'b0;
			sarChan <= CH_EXT;
			sarFilt <= FILT_NONE;
			sarRef <= AREF_1V25;
			sarLowRes <= 1'b0;
			dacRef <= DREF_1V25;
			inputPinAnalog <= 1'b1;
			outputPinAnalog <= 1'b1;
		end else begin
			sarStart <= adcTick && (aState_reg == A_IDLE);
			sarChan <= adcCfg_reg.chan;
			sarFilt <= adcCfg_reg.filt;
			sarRef <= adcCfg_reg.refSrc;
			sarLowRes <= adcCfg_reg.lowRes;
			dacRef <= dacCfg_reg.refSrc;
			// an enabled converter keeps its pin; only an idle one is handed over
			inputPinAnalog <= adcCfg_reg.enable || !pinAltFunc;
			outputPinAnalog <= dacCfg_reg.enable || !pinAltFunc;
		end
	end
	// ************************************************************
	// dac path: host code or sine table, then calibration
	// ************************************************************
	localparam logic [11:0] SINE_LUT [SINE_LEN] = '{
		12'h800, 12'h98f, 12'hb0f, 12'hc71, 12'hda7, 12'hea6, 12'hf63, 12'hfd8,
		12'hfff, 12'hfd8, 12'hf63, 12'hea6, 12'hda7, 12'hc71, 12'hb0f, 12'h98f,
		12'h800, 12'h671, 12'h4f1, 12'h38f, 12'h259, 12'h15a, 12'h09d, 12'h028,
		12'h001, 12'h028, 12'h09d, 12'h15a, 12'h259, 12'h38f, 12'h4f1, 12'h671};
	logic [RATE_CW-1:0] dacCnt_reg;
	logic [11:0] hostCode_reg;
	logic [SINE_AW-1:0] sineIdx_reg;
	wire dacTick = dacCfg_reg.enable && (dacCnt_reg == '0);
	wire [11:0] rawCode = dacCfg_reg.sineMode ? SINE_LUT[sineIdx_reg] : hostCode_reg;
	// gain is unsigned with 0x80 as unity, offset signed; the sum saturates
	wire [19:0] gained = 20'(rawCode * dacCfg_reg.gain) >> GAIN_SHIFT;
	wire signed [20:0] calSum = $signed({1'b0, gained}) + 21'(dacCfg_reg.offset);
	wire [11:0] calCode = (calSum < 0) ? 12'h000 :
		(calSum > $signed({9'h000, DAC_MAX})) ? DAC_MAX : calSum[11:0];
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			dacCnt_reg <= '0;
			hostCode_reg <= '0;
			sineIdx_reg <= '0;
			dacOut <= '0;
			dacStrobe <= 1'b0;
		end else begin
			dacStrobe <= dacTick;
			if (dacCodeValid) hostCode_reg <= dacCode;
			if (!dacCfg_reg.enable || dacCnt_reg == '0) dacCnt_reg <= RATE_CW'(DAC_PER - 1);
			else dacCnt_reg <= dacCnt_reg - 1'b1;
			if (dacTick) begin
				dacOut <= calCode;
				if (dacCfg_reg.sineMode) sineIdx_reg <= sineIdx_reg + dacCfg_reg.sineStep;
			end
		end
	end
	// ************************************************************
	// serial command receiver, 8N1; the text parser sits downstream
	// ************************************************************
	logic [2:0] rxSync_reg;
	logic rxLevel_reg;
	logic rxBusy_reg;
	logic [UART_CW-1:0] bitCnt_reg;
	logic [3:0] bitIdx_reg;
	logic [8:0] shift_reg;
	// a level change counts only once the second and third stages agree
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			rxSync_reg <= 3'h7;
			rxLevel_reg <= 1'b1;
		end else begin
			rxSync_reg <= {rxSync_reg[1:0], uartRx};
			if (rxSync_reg[1] == rxSync_reg[2]) rxLevel_reg <= rxSync_reg[2];
		end
	end
	wire bitDue = rxBusy_reg && (bitCnt_reg == '0);
	wire frameEnd = bitDue && (bitIdx_reg == 4'(UART_DATA_BITS + 1));
	// start found at mid bit; a false start is dropped when it reads high
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			rxBusy_reg <= 1'b0;
			bitCnt_reg <= '0;
			bitIdx_reg <= '0;
			shift_reg <= '0;
			rxByte <= '0;
			rxValid <= 1'b0;
			rxFrameErr <= 1'b0;
		end else begin
			rxValid <= 1'b0;
			rxFrameErr <= 1'b0;
			if (!rxBusy_reg) begin
				if (!rxLevel_reg) begin
					rxBusy_reg <= 1'b1;
					bitCnt_reg <= UART_CW'(UART_BIT_CYCLES / 2);
					bitIdx_reg <= '0;
				end
			end else if (bitDue) begin
				bitCnt_reg <= UART_CW'(UART_BIT_CYCLES - 1);
				bitIdx_reg <= bitIdx_reg + 1'b1;
				shift_reg <= {rxLevel_reg, shift_reg[8:1]};
				if (bitIdx_reg == '0 && rxLevel_reg) rxBusy_reg <= 1'b0;
				if (frameEnd) begin
					rxBusy_reg <= 1'b0;
					rxByte <= shift_reg[8:1];
					rxValid <= rxLevel_reg;
					rxFrameErr <= !rxLevel_reg;
				end
			end else begin
				bitCnt_reg <= bitCnt_reg - 1'b1;
			end
		end
	end
	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	start_spacing_a: assert property (sarStart |=> !sarStart [*8])
		else $error("sar starts too close together");
	adc_off_a: assert property (!adcCfg_reg.enable |=> !sarStart)
		else $error("sar started while adc disabled");
	plain_result_a: assert property (take && !adcCfg_reg.osEnable |=>
		resultValid && result == {4'h0, $past(sample)})
		else $error("plain conversion result wrong");
	dump_clear_a: assert property (take && adcCfg_reg.osEnable && accDump |=>
		resultValid && acc_reg == '0 && accCnt_reg == '0)
		else $error("accumulator not dumped");
	acc_hold_a: assert property (take && adcCfg_reg.osEnable && !accDump |=>
		!resultValid && accCnt_reg == $past(accCntNext))
		else $error("accumulation step wrong");
	dac_spacing_a: assert property (dacStrobe |=> !dacStrobe [*8])
		else $error("dac updates too fast");
	dac_cal_a: assert property (dacTick |=> dacStrobe && dacOut == $past(calCode))
		else $error("dac output not calibrated code");
	sine_step_a: assert property (dacTick && dacCfg_reg.sineMode |=>
		sineIdx_reg == $past(sineIdx_reg) + $past(dacCfg_reg.sineStep))
		else $error("sine index did not advance");
	pin_keep_a: assert property (adcCfg_reg.enable |=> inputPinAnalog)
		else $error("input pin taken from enabled adc");
	rx_pulse_a: assert property (rxValid |=> !rxValid && !rxBusy_reg)
		else $error("receive valid longer than a cycle");
	// selections reach the macro one cycle after capture, never a stale mix
	sel_follow_a: assert property (1'b1 |=> sarChan == $past(adcCfg_reg.chan) &&
		sarFilt == $past(adcCfg_reg.filt) && sarRef == $past(adcCfg_reg.refSrc))
		else $error("sar selections do not follow configuration");
	dac_ref_a: assert property (1'b1 |=> dacRef == $past(dacCfg_reg.refSrc))
		else $error("dac reference does not follow configuration");
	dac_off_a: assert property (!dacCfg_reg.enable |=> !dacStrobe)
		else $error("dac updated while disabled");
	plain_width_a: assert property (resultValid && !$past(adcCfg_reg.osEnable) |->
		result[15:12] == 4'h0)
		else $error("plain result wider than twelve bits");
	lowres_width_a: assert property (resultValid &&
		$past(!adcCfg_reg.osEnable && adcCfg_reg.lowRes) |-> result[15:6] == 10'h000)
		else $error("low resolution result wider than six bits");
	rx_excl_a: assert property (rxFrameErr |-> !rxValid)
		else $error("frame error and valid together");
	os_dump_c: cover property (resultValid && adcCfg_reg.osEnable);
	lowres_c: cover property (take && adcCfg_reg.lowRes);
	sine_c: cover property (dacStrobe && dacCfg_reg.sineMode);
	rx_byte_c: cover property (rxValid);
endmodule : adcc_converter_control

// ==== src/adcc_pkg.sv ====
// shared constants and carriers of the converter control
package adcc_pkg;
	// ************************************************************
	// clock, rates and serial timing
	// ************************************************************
	localparam int CLK_HZ = 200_000_000;
	localparam int CLK_KHZ = 200_000;
	localparam int ADC12_KSPS = 1000;
	localparam int ADC6_KSPS = 1860;
	localparam int DAC_KSPS = 500;
	// least sample period, rounded up to whole cycles
	localparam int ADC12_PER = (CLK_KHZ + ADC12_KSPS - 1) / ADC12_KSPS;
	localparam int ADC6_PER = (CLK_KHZ + ADC6_KSPS - 1) / ADC6_KSPS;
	localparam int DAC_PER = (CLK_KHZ + DAC_KSPS - 1) / DAC_KSPS;
	localparam int RATE_CW = 9;
	localparam int BAUD_BPS = 9600;
	localparam int UART_BIT_CYC = CLK_HZ / BAUD_BPS;
	localparam int UART_CW = 16;
	localparam int UART_DATA_BITS = 8;
	// ************************************************************
	// widths and calibration
	// ************************************************************
	localparam int SAMPLE_W = 12;
	localparam int RESULT_W = 16;
	localparam int ACC_W = 20;
	localparam logic [3:0] OS_LOG2_MIN = 4'h1;
	localparam logic [3:0] OS_LOG2_MAX = 4'h8;
	localparam logic [3:0] OS_RES_LOG2 = 4'h4;
	localparam int GAIN_SHIFT = 7;
	localparam int SINE_AW = 5;
	localparam int SINE_LEN = 32;
	localparam logic [11:0] DAC_MAX = 12'hfff;
	// ************************************************************
	// selections
	// ************************************************************
	typedef enum logic [2:0] {CH_EXT = 3'b000, CH_TEMP = 3'b001, CH_VDD = 3'b010,
		CH_GND = 3'b011, CH_DACLOOP = 3'b100} adcc_chan_t;
	typedef enum logic [1:0] {FILT_NONE = 2'b00, FILT_RC = 2'b01,
		FILT_DECAP = 2'b10} adcc_filt_t;
	typedef enum logic [2:0] {AREF_1V25 = 3'b000, AREF_2V5 = 3'b001, AREF_VDD = 3'b010,
		AREF_5VDIFF = 3'b011, AREF_2VDD = 3'b100} adcc_aref_t;
	typedef enum logic [1:0] {DREF_1V25 = 2'b00, DREF_2V5 = 2'b01,
		DREF_VDD = 2'b10} adcc_dref_t;
	typedef struct packed {
		logic enable;
		logic lowRes;
		logic osEnable;
		logic [3:0] osLog2;
		adcc_chan_t chan;
		adcc_filt_t filt;
		adcc_aref_t refSrc;
	} adcc_adc_cfg_t;
	typedef struct packed {
		logic enable;
		logic sineMode;
		logic [4:0] sineStep;
		adcc_dref_t refSrc;
		logic signed [7:0] offset;
		logic [7:0] gain;
	} adcc_dac_cfg_t;
	localparam adcc_adc_cfg_t ADC_CFG_RST = '{enable: 1'b0, lowRes: 1'b0, osEnable: 1'b0,
		osLog2: 4'h4, chan: CH_EXT, filt: FILT_NONE, refSrc: AREF_1V25};
	localparam adcc_dac_cfg_t DAC_CFG_RST = '{enable: 1'b0, sineMode: 1'b0, sineStep: 5'h01,
		refSrc: DREF_1V25, offset: 8'h00, gain: 8'h80};
endpackage : adcc_pkg

// ==== verification/adcc_sar_model.sv ====
// behavioural sar macro that answers each start after a chosen latency
`timescale 1ns/10ps
module adcc_sar_model (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// conversion request and the value to hand back
	input wire logic sarStart,
	input wire logic [11:0] value,
	input wire logic [7:0] latency,
	// answer towards the converter control
	output logic sarDone,
	output logic [11:0] sarData
);
	logic [7:0] cycleCount_reg;

	// data toggles outside the done pulse, so a stale sample never passes for a fresh one
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			cycleCount_reg <= 8'h00;
			sarDone <= 1'b0;
			sarData <= 12'h000;
		end else begin
			sarDone <= 1'b0;
			sarData <= ~sarData;
			if (sarStart) begin
				cycleCount_reg <= latency;
			end else if (cycleCount_reg == 8'h01) begin
				sarDone <= 1'b1;
				sarData <= value;
				cycleCount_reg <= 8'h00;
			end else if (cycleCount_reg != 8'h00) begin
				cycleCount_reg <= cycleCount_reg - 8'h01;
			end
		end
	end
endmodule : adcc_sar_model

// ==== verification/tb_adcc_converter_control.sv ====
// self-checking bench of the converter control
`timescale 1ns/10ps
module tb_adcc_converter_control import adcc_pkg::*; ;
	localparam int BITC = 16;
	logic mclk, reset, pinAltFunc, dacCodeValid, uartRx, sarDone, sarStart, sarLowRes;
	logic resultValid, dacStrobe, inputPinAnalog, outputPinAnalog, rxValid, rxFrameErr;
	logic [11:0] dacCode, sarValue, sarData, dacOut;
	logic [7:0] sarLatency, rxByte;
	logic [15:0] result;
	adcc_adc_cfg_t adcCfg;
	adcc_dac_cfg_t dacCfg;
	adcc_chan_t sarChan;
	adcc_filt_t sarFilt;
	adcc_aref_t sarRef;
	adcc_dref_t dacRef;
	int mismatches, checked, cyc;

	// short bit time keeps the serial frames cheap to simulate
	adcc_converter_control #(.UART_BIT_CYCLES(BITC)) u_dut (.mclk(mclk), .reset(reset),
		.adcCfg(adcCfg), .dacCfg(dacCfg), .pinAltFunc(pinAltFunc), .dacCode(dacCode),
		.dacCodeValid(dacCodeValid), .sarDone(sarDone), .sarData(sarData), .sarStart(sarStart),
		.sarChan(sarChan), .sarFilt(sarFilt), .sarRef(sarRef), .sarLowRes(sarLowRes),
		.result(result), .resultValid(resultValid), .dacOut(dacOut), .dacStrobe(dacStrobe),
		.dacRef(dacRef), .inputPinAnalog(inputPinAnalog), .outputPinAnalog(outputPinAnalog),
		.uartRx(uartRx), .rxByte(rxByte), .rxValid(rxValid), .rxFrameErr(rxFrameErr));
	adcc_sar_model u_sar (.mclk(mclk), .reset(reset), .sarStart(sarStart), .value(sarValue),
		.latency(sarLatency), .sarDone(sarDone), .sarData(sarData));

	// clock and a free cycle count for period measurements
	initial mclk = 1'b0;
	always #2.5 mclk = ~mclk;
	always @(posedge mclk) cyc <= cyc + 1;

	// ************************************************************
	// shared tasks
	// ************************************************************
	task automatic complete_run();
		$display("mismatches %0d checked %0d", mismatches, checked);
		if (mismatches == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : complete_run

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// bounded wait for one of the pulse outputs; running out ends the run
	task automatic waitSig(input int sel, input int limit);
		logic s;
		for (int n = 0; n < limit; n++) begin
			@(posedge mclk);
			#1;
			s = sel == 0 ? resultValid : sel == 1 ? dacStrobe : sel == 2 ? rxValid : rxFrameErr;
			if (s === 1'b1) return;
		end
		chk({15'h0000, 1'b0}, 16'h0001);
		complete_run();
	endtask : waitSig

	task automatic setCfg(input adcc_adc_cfg_t a, input adcc_dac_cfg_t d);
		@(posedge mclk);
		adcCfg <= a;
		dacCfg <= d;
	endtask : setCfg

	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic resetRun();
		int pulses;
		pulses = 0;
		for (int i = 0; i < 450; i++) begin
			@(posedge mclk);
			#1;
			if ({sarStart, dacStrobe, resultValid} !== 3'b000) pulses++;
		end
		chk(16'(pulses), 16'h0000);
		chk({11'h000, sarChan, sarFilt}, 16'h0000);
		chk({14'h0000, inputPinAnalog, outputPinAnalog}, 16'h0003);
	endtask : resetRun

	task automatic selRun();
		adcc_adc_cfg_t a;
		adcc_dac_cfg_t d;
		a = ADC_CFG_RST;
		d = DAC_CFG_RST;
		for (int i = 0; i < 5; i++) begin
			a.chan = adcc_chan_t'(i);
			a.filt = adcc_filt_t'(i % 3);
			a.refSrc = adcc_aref_t'(i);
			a.lowRes = i[0];
			d.refSrc = adcc_dref_t'(i % 3);
			setCfg(a, d);
			repeat (3) @(posedge mclk);
			#1;
			chk({7'h00, sarLowRes, sarChan, sarFilt, sarRef},
				{7'h00, a.lowRes, a.chan, a.filt, a.refSrc});
			chk({14'h0000, dacRef}, {14'h0000, d.refSrc});
		end
		setCfg(ADC_CFG_RST, DAC_CFG_RST);
	endtask : selRun

	// two results in a row: value, spacing, and a fresh accumulation each time
	task automatic adcRun(input adcc_adc_cfg_t a, input logic [11:0] v, input logic [15:0] exp,
		input int per);
		int t0;
		setCfg(a, DAC_CFG_RST);
		sarValue <= v;
		waitSig(0, per * 2 + 100);
		t0 = cyc;
		chk(result, exp);
		waitSig(0, per + 100);
		chk(16'(cyc - t0), 16'(per));
		chk(result, exp);
		setCfg(ADC_CFG_RST, DAC_CFG_RST);
		repeat (300) @(posedge mclk);
	endtask : adcRun

	task automatic dacRun(input adcc_dac_cfg_t d, input logic [11:0] code, input logic [11:0] exp);
		int t0;
		@(posedge mclk);
		dacCode <= code;
		dacCodeValid <= 1'b1;
		setCfg(ADC_CFG_RST, d);
		dacCodeValid <= 1'b0;
		waitSig(1, 500);
		t0 = cyc;
		waitSig(1, 500);
		chk(16'(cyc - t0), 16'h0190);
		chk({4'h0, dacOut}, {4'h0, exp});
		setCfg(ADC_CFG_RST, DAC_CFG_RST);
	endtask : dacRun

	// a quarter-period step: codes half a period apart sum to full scale
	task automatic sineRun();
		adcc_dac_cfg_t d;
		logic [11:0] v [4];
		logic [15:0] s;
		d = DAC_CFG_RST;
		d.enable = 1'b1;
		d.sineMode = 1'b1;
		d.sineStep = 5'h08;
		setCfg(ADC_CFG_RST, d);
		for (int i = 0; i < 4; i++) begin
			waitSig(1, 500);
			v[i] = dacOut;
		end
		s = 16'(v[0]) + 16'(v[2]);
		chk({15'h0000, s >= 16'h0ffe && s <= 16'h1002}, 16'h0001);
		chk({15'h0000, v[1] !== v[0]}, 16'h0001);
		setCfg(ADC_CFG_RST, DAC_CFG_RST);
	endtask : sineRun

	// frame sent lsb first; the stop bit stays until the receiver answers
	task automatic uartRun(input logic [7:0] b, input logic stopBit, input int sel);
		logic [9:0] frame;
		frame = {stopBit, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge mclk);
			uartRx <= frame[i];
			if (i < 9) repeat (BITC - 1) @(posedge mclk);
		end
		waitSig(sel, BITC * 2);
		chk({8'h00, rxByte}, {8'h00, b});
		@(posedge mclk);
		uartRx <= 1'b1;
		repeat (BITC * 2) @(posedge mclk);
	endtask : uartRun

	task automatic pinRun();
		adcc_adc_cfg_t a;
		a = ADC_CFG_RST;
		a.enable = 1'b1;
		@(posedge mclk);
		pinAltFunc <= 1'b1;
		repeat (4) @(posedge mclk);
		#1;
		chk({14'h0000, inputPinAnalog, outputPinAnalog}, 16'h0000);
		setCfg(a, DAC_CFG_RST);
		repeat (4) @(posedge mclk);
		#1;
		chk({14'h0000, inputPinAnalog, outputPinAnalog}, 16'h0002);
		setCfg(ADC_CFG_RST, DAC_CFG_RST);
		pinAltFunc <= 1'b0;
		repeat (300) @(posedge mclk);
		#1;
		chk({14'h0000, inputPinAnalog, outputPinAnalog}, 16'h0003);
	endtask : pinRun

	// main sequence
	initial begin
		adcc_adc_cfg_t a;
		adcc_dac_cfg_t d;
		reset = 1'b1;
		adcCfg = ADC_CFG_RST;
		dacCfg = DAC_CFG_RST;
		{pinAltFunc, dacCodeValid, dacCode, sarValue} = '0;
		uartRx = 1'b1;
		sarLatency = 8'h28;
		{mismatches, checked} = '0;
		repeat (6) @(posedge mclk);
		reset <= 1'b0;
		resetRun();
		selRun();
		a = ADC_CFG_RST;
		a.enable = 1'b1;
		adcRun(a, 12'habc, 16'h0abc, 200);
		sarLatency <= 8'h01;
		a.lowRes = 1'b1;
		adcRun(a, 12'habc, 16'h002a, 108);
		a.lowRes = 1'b0;
		a.osEnable = 1'b1;
		adcRun(a, 12'habc, 16'habc0, 3200);
		a.osLog2 = 4'h1;
		adcRun(a, 12'h100, 16'h1000, 400);
		// a ratio below range is clamped to two samples
		a.osLog2 = 4'h0;
		adcRun(a, 12'h100, 16'h1000, 400);
		d = DAC_CFG_RST;
		d.enable = 1'b1;
		dacRun(d, 12'h123, 12'h123);
		d.gain = 8'h40;
		d.offset = 8'h05;
		dacRun(d, 12'h400, 12'h205);
		d.gain = 8'hff;
		dacRun(d, 12'hfff, 12'hfff);
		d.gain = 8'h80;
		d.offset = 8'hf0;
		dacRun(d, 12'h005, 12'h000);
		sineRun();
		uartRun(8'ha5, 1'b1, 2);
		uartRun(8'h3c, 1'b0, 3);
		pinRun();
		complete_run();
	end
endmodule : tb_adcc_converter_control
